// ### pkg/fpc_pkg.sv
package fpc_pkg;
	// Address split: sector above page
	localparam int SEC_W = 2;
	localparam int PG_W = 4;
	localparam int ADR_W = SEC_W + PG_W;
	localparam int PAGES = 64;
	localparam int CNT_W = 12;
	localparam int MEM_W = CNT_W + 1;
	localparam int LOCK_BIT = CNT_W;
	localparam int TMR_W = 20;
	// Commit time per page, erase included
	localparam longint PROG_TIME_NS = 6800000;
	localparam longint CLK_NS = 8;
	localparam int PROG_CYCLES = int'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
	// Status codes
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_REFUSED = 2'h1;
	localparam logic [1:0] ST_ECC = 2'h2;
	localparam logic [1:0] ST_WEAR = 2'h3;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PBADDR = 8'h04;
	localparam logic [7:0] A_THRESH = 8'h08;
	localparam logic [7:0] A_IRQ_STAT = 8'h0C;
	localparam logic [7:0] A_IRQ_EN = 8'h10;
	localparam logic [7:0] A_IRQ_CLR = 8'h14;
	localparam logic [7:0] A_OPSTAT = 8'h18;
	// Field positions and reset values
	localparam int CTRL_ECC_FORCE = 0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_W = 2;
	localparam int OPS_BUSY = 0;
	localparam int OPS_CODE = 1;
	localparam int OPS_STATE = 4;
	localparam logic [CNT_W-1:0] THRESH_RST = 12'h3E8;
	localparam logic [ADR_W-1:0] PBADDR_RST = 6'h00;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_RD = 5'h02,
		S_CHK = 5'h04,
		S_WR = 5'h08,
		S_DONE = 5'h10
	} fpc_state_t;
endpackage

// ### core/fpc_page_mem.sv
`timescale 1ns/1ns
// Per-page lock bit and write count; read data registered
module fpc_page_mem (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [fpc_pkg::ADR_W-1:0] waddr_i,
	input wire logic [fpc_pkg::MEM_W-1:0] wdata_i,
	input wire logic [fpc_pkg::ADR_W-1:0] raddr_i,
	output logic [fpc_pkg::MEM_W-1:0] rdata_o
);
	logic [fpc_pkg::MEM_W-1:0] mem [fpc_pkg::PAGES];

	// Fresh array: unlocked, never written
	initial begin
		for (int i = 0; i < fpc_pkg::PAGES; i++) begin
			mem[i] = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ### core/fpc_commit_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - A commit request starts copying the whole page buffer into the array.
// - A commit, erase included, is timed to 6.8 ms per page.
// - Busy stays high for the whole write and falls only after it ends.
// - A commit compares the sector and page address with the stored page buffer address.
// - On a mismatch without redirect the commit aborts with an error status.
// - With redirect the buffer goes to the addressed page unless that page is locked.
// - Set-write-lock with a commit puts the addressed page into locked mode.
// - A locked page is never overwritten by a later commit or erase.
// - Status 01 leaves the page unchanged; any other status means it was modified.
// - A commit aimed at a locked page ends with status 01.
// - Status 11 reports a write count above the write threshold.
// - Status 10 reports an uncorrectable error in the committed page.
// - Redirect is sampled only with a commit or erase request.
module fpc_commit_ctrl #(
	parameter int PROG_CYCLES = fpc_pkg::PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic commit_req_i,
	input wire logic page_erase_request_i,
	input wire logic redirect_target_page_i,
	input wire logic set_write_lock_i,
	input wire logic [fpc_pkg::ADR_W-1:0] addr_i,
	output logic busy_o,
	output logic [1:0] status_o,
	output logic irq_o
);
	fpc_pkg::fpc_state_t state_ff;
	logic ack_ff, busy_ff, irq_ff, ecc_force_ff;
	logic is_commit_ff, redir_ff, lock_req_ff;
	logic [31:0] dat_ff;
	logic [1:0] code_ff;
	logic [fpc_pkg::ADR_W-1:0] adr_ff, pb_addr_ff;
	logic [fpc_pkg::CNT_W-1:0] thresh_ff;
	logic [fpc_pkg::IRQ_W-1:0] istat_ff, ien_ff;
	logic [fpc_pkg::TMR_W-1:0] tmr_ff;
	logic [fpc_pkg::MEM_W-1:0] rdata, wdata;
	logic [fpc_pkg::CNT_W-1:0] nxt_count;
	logic accept, wb_wr, wb_rd, mismatch, locked, refuse, mem_we, done_ev;
	logic [1:0] fin_code;
	logic [31:0] m_ctrl, m_pb, m_th, m_en;
	logic [fpc_pkg::IRQ_W-1:0] irq_clr, irq_set;

	// Byte-lane merge for register writes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Merged write words, sliced per register below
	assign m_ctrl = wmerge(32'h0, wb_dat_i, wb_sel_i);
	assign m_pb = wmerge({26'h0, pb_addr_ff}, wb_dat_i, wb_sel_i);
	assign m_th = wmerge({20'h0, thresh_ff}, wb_dat_i, wb_sel_i);
	assign m_en = wmerge({30'h0, ien_ff}, wb_dat_i, wb_sel_i);

	// Writes land on the edge that shows ack, the one the master samples
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
	assign wb_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
	// Requests only taken when idle; a request under busy is ignored
	assign accept = (state_ff == fpc_pkg::S_IDLE) && (commit_req_i || page_erase_request_i);
	assign locked = rdata[fpc_pkg::LOCK_BIT];
	assign mismatch = is_commit_ff && (adr_ff != pb_addr_ff);
	// Locked target, or mismatch with no redirect
	assign refuse = locked || (mismatch && !redir_ff);
	assign nxt_count = rdata[fpc_pkg::CNT_W-1:0] + 12'h001;
	assign mem_we = (state_ff == fpc_pkg::S_WR) && (tmr_ff == '0);
	// Lock kept, or set by the commit qualifier
	assign wdata = {locked || (is_commit_ff && lock_req_ff), nxt_count};
	assign done_ev = (state_ff == fpc_pkg::S_DONE);

	// Completion code: wear over ECC over good
	always_comb begin
		if (nxt_count > thresh_ff) begin
			fin_code = fpc_pkg::ST_WEAR;
		end else if (ecc_force_ff && is_commit_ff) begin
			fin_code = fpc_pkg::ST_ECC;
		end else begin
			fin_code = fpc_pkg::ST_OK;
		end
	end

	fpc_page_mem u_mem (
		.clk_i(clk_i),
		.we_i(mem_we),
		.waddr_i(adr_ff),
		.wdata_i(wdata),
		.raddr_i(adr_ff),
		.rdata_o(rdata)
	);

	// Operation sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= fpc_pkg::S_IDLE;
			tmr_ff <= '0;
		end else begin
			case (state_ff)
				fpc_pkg::S_IDLE: begin
					if (accept) begin
						state_ff <= fpc_pkg::S_RD;
					end
				end
				fpc_pkg::S_RD: begin
					state_ff <= fpc_pkg::S_CHK;
				end
				fpc_pkg::S_CHK: begin
					if (refuse) begin
						state_ff <= fpc_pkg::S_DONE;
					end else begin
						state_ff <= fpc_pkg::S_WR;
						tmr_ff <= fpc_pkg::TMR_W'(PROG_CYCLES - 1);
					end
				end
				fpc_pkg::S_WR: begin
					if (tmr_ff == '0) begin
						state_ff <= fpc_pkg::S_DONE;
					end else begin
						tmr_ff <= tmr_ff - 1'b1;
					end
				end
				fpc_pkg::S_DONE: begin
					state_ff <= fpc_pkg::S_IDLE;
				end
				default: begin
					state_ff <= fpc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Request capture; qualifiers looked at only on acceptance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adr_ff <= '0;
			is_commit_ff <= 1'b0;
			redir_ff <= 1'b0;
			lock_req_ff <= 1'b0;
		end else if (accept) begin
			adr_ff <= addr_i;
			is_commit_ff <= commit_req_i;
			redir_ff <= redirect_target_page_i;
			lock_req_ff <= set_write_lock_i && commit_req_i;
		end
	end

	// Busy from acceptance until the done cycle ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
		end else if (accept) begin
			busy_ff <= 1'b1;
		end else if (done_ev) begin
			busy_ff <= 1'b0;
		end
	end

	// Status code lands one cycle before busy falls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_ff <= fpc_pkg::ST_OK;
		end else if ((state_ff == fpc_pkg::S_CHK) && refuse) begin
			code_ff <= fpc_pkg::ST_REFUSED;
		end else if (mem_we) begin
			code_ff <= fin_code;
		end
	end

	// Software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ecc_force_ff <= 1'b0;
			pb_addr_ff <= fpc_pkg::PBADDR_RST;
			thresh_ff <= fpc_pkg::THRESH_RST;
			ien_ff <= '0;
		end else if (wb_wr) begin
			case (wb_adr_i)
				fpc_pkg::A_CTRL: begin
					ecc_force_ff <= m_ctrl[fpc_pkg::CTRL_ECC_FORCE];
				end
				fpc_pkg::A_PBADDR: begin
					pb_addr_ff <= m_pb[fpc_pkg::ADR_W-1:0];
				end
				fpc_pkg::A_THRESH: begin
					thresh_ff <= m_th[fpc_pkg::CNT_W-1:0];
				end
				fpc_pkg::A_IRQ_EN: begin
					ien_ff <= m_en[fpc_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Clear mask from the low byte only; events from the done cycle
	assign irq_clr = (wb_wr && (wb_adr_i == fpc_pkg::A_IRQ_CLR) && wb_sel_i[0]) ?
		wb_dat_i[fpc_pkg::IRQ_W-1:0] : '0;
	assign irq_set[fpc_pkg::IRQ_DONE] = done_ev;
	assign irq_set[fpc_pkg::IRQ_ERR] = done_ev && (code_ff != fpc_pkg::ST_OK);

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			istat_ff <= '0;
		end else begin
			istat_ff <= (istat_ff & ~irq_clr) | irq_set;
		end
	end

	// Interrupt level, one cycle behind the status bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(istat_ff & ien_ff);
		end
	end

	// Bus answer one cycle after strobe; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
		end else begin
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
			if (wb_rd) begin
				case (wb_adr_i)
					fpc_pkg::A_CTRL: dat_ff <= {31'h0, ecc_force_ff};
					fpc_pkg::A_PBADDR: dat_ff <= {26'h0, pb_addr_ff};
					fpc_pkg::A_THRESH: dat_ff <= {20'h0, thresh_ff};
					fpc_pkg::A_IRQ_STAT: dat_ff <= {30'h0, istat_ff};
					fpc_pkg::A_IRQ_EN: dat_ff <= {30'h0, ien_ff};
					fpc_pkg::A_OPSTAT: dat_ff <= {23'h0, state_ff, 1'b0, code_ff, busy_ff};
					default: dat_ff <= 32'h0;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign busy_o = busy_ff;
	assign status_o = code_ff;
	assign irq_o = irq_ff;

	// Checks
	a_busy_on_req: assert property (@(posedge clk_i) disable iff (rst_i)
		accept |=> busy_o && (state_ff == fpc_pkg::S_RD))
		else $error("busy not raised after request");
	a_busy_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == fpc_pkg::S_WR) |-> busy_o)
		else $error("busy low while writing");
	a_write_time: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_ff == fpc_pkg::S_WR) |-> tmr_ff == fpc_pkg::TMR_W'(PROG_CYCLES - 1))
		else $error("write timer misloaded");
	a_mismatch_abort: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == fpc_pkg::S_CHK && mismatch && !redir_ff) |=> done_ev && status_o == fpc_pkg::ST_REFUSED)
		else $error("mismatch did not abort");
	a_lock_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == fpc_pkg::S_CHK && locked) |=> status_o == fpc_pkg::ST_REFUSED ##1 !busy_o)
		else $error("locked page not refused");
	a_no_write_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		mem_we |=> status_o != fpc_pkg::ST_REFUSED)
		else $error("write ended with refused code");
	a_lock_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		(mem_we && lock_req_ff) |-> wdata[fpc_pkg::LOCK_BIT])
		else $error("lock request not stored");
	a_redir_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		!accept |=> $stable(redir_ff))
		else $error("redirect sampled outside request");
	a_ok_status: assert property (@(posedge clk_i) disable iff (rst_i)
		(mem_we && fin_code == fpc_pkg::ST_OK) |=> status_o == fpc_pkg::ST_OK ##1 !busy_o)
		else $error("good commit not reported as 00");
	a_wear_code: assert property (@(posedge clk_i) disable iff (rst_i)
		(mem_we && nxt_count > thresh_ff) |=> status_o == fpc_pkg::ST_WEAR)
		else $error("threshold not reported");
	a_ecc_code: assert property (@(posedge clk_i) disable iff (rst_i)
		(mem_we && is_commit_ff && ecc_force_ff && nxt_count <= thresh_ff) |=> status_o == fpc_pkg::ST_ECC)
		else $error("ecc failure not reported");
	a_busy_release: assert property (@(posedge clk_i) disable iff (rst_i)
		done_ev |=> !busy_o && state_ff == fpc_pkg::S_IDLE)
		else $error("busy held after done");
	c_commit_ok: cover property (@(posedge clk_i) mem_we && is_commit_ff && fin_code == fpc_pkg::ST_OK);
	c_abort: cover property (@(posedge clk_i) state_ff == fpc_pkg::S_CHK && mismatch && !redir_ff);
	c_redirect: cover property (@(posedge clk_i) mem_we && redir_ff && mismatch);
	c_locked: cover property (@(posedge clk_i) state_ff == fpc_pkg::S_CHK && locked);
	c_wear: cover property (@(posedge clk_i) mem_we && nxt_count > thresh_ff);
endmodule

// ### bench/fpc_req_model.sv
`timescale 1ns/1ns
// User logic issuing commit and erase requests
module fpc_req_model (
	input wire logic clk_i,
	input wire logic busy_i,
	output logic commit_req_o,
	output logic erase_req_o,
	output logic redirect_o,
	output logic lock_o,
	output logic [fpc_pkg::ADR_W-1:0] addr_o
);
	// Idle outputs at time zero
	initial begin
		commit_req_o = 1'b0;
		erase_req_o = 1'b0;
		redirect_o = 1'b0;
		lock_o = 1'b0;
		addr_o = '0;
	end
	// One request, then count busy cycles at falling edges
	task automatic issue(input logic erase, input logic [fpc_pkg::ADR_W-1:0] adr, input logic redir,
		input logic lock, output int n_busy);
		int g;
		n_busy = 0;
		g = 0;
		while (busy_i !== 1'b0) @(negedge clk_i);
		@(posedge clk_i);
		commit_req_o <= !erase;
		erase_req_o <= erase;
		redirect_o <= redir;
		lock_o <= lock;
		addr_o <= adr;
		@(posedge clk_i);
		// Qualifiers scrambled once sampled, so a late sample shows
		commit_req_o <= 1'b0;
		erase_req_o <= 1'b0;
		redirect_o <= !redir;
		lock_o <= !lock;
		addr_o <= ~adr;
		@(negedge clk_i);
		while (busy_i !== 1'b1 && g < 3) begin
			g++;
			@(negedge clk_i);
		end
		while (busy_i === 1'b1) begin
			n_busy++;
			@(negedge clk_i);
		end
	endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	// Short commit time keeps the run small
	localparam int P = 20;
	logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, busy, irq, c_req, e_req, redir, lock;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dw, wb_dr, rd;
	logic [1:0] status;
	logic [fpc_pkg::ADR_W-1:0] addr;
	int mismatches = 0, n_checks = 0, cycles = 0, n_ok, n_ref, n;
	fpc_commit_ctrl #(.PROG_CYCLES(P)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr),
		.wb_ack_o(wb_ack), .commit_req_i(c_req), .page_erase_request_i(e_req), .redirect_target_page_i(redir),
		.set_write_lock_i(lock), .addr_i(addr), .busy_o(busy), .status_o(status), .irq_o(irq));
	fpc_req_model i_req (.clk_i(clk_i), .busy_i(busy), .commit_req_o(c_req), .erase_req_o(e_req),
		.redirect_o(redir), .lock_o(lock), .addr_o(addr));
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Timeout well above the expected run length
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Classic single Wishbone cycle; released only at the ack edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dw <= d;
		wb_sel <= 4'hF;
		@(posedge clk_i);
		while (wb_ack !== 1'b1) @(posedge clk_i);
		q = wb_dr;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// Return mid-cycle so callers look at settled outputs
		@(negedge clk_i);
	endtask
	task automatic op(input logic e, input logic [5:0] a, input logic r, input logic l, input logic [1:0] x,
		output int nb);
		i_req.issue(e, a, r, l, nb);
		`CHK(status, x)
	endtask
	// Reset values and unmapped place
	task automatic t_reset();
		wb(1'b0, fpc_pkg::A_THRESH, 32'h0, rd);
		`CHK(rd, 32'h000003E8)
		wb(1'b0, fpc_pkg::A_PBADDR, 32'h0, rd);
		`CHK(rd, 32'h00000000)
		wb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
		wb(1'b0, 8'h40, 32'h0, rd);
		`CHK(rd, 32'h00000000)
		`CHK({busy, status}, 3'h0)
		wb(1'b0, fpc_pkg::A_OPSTAT, 32'h0, rd);
		`CHK(rd, 32'h00000010)
	endtask
	// Matching commit, then sector and page mismatches
	task automatic t_commit();
		wb(1'b1, fpc_pkg::A_PBADDR, 32'h0000001A, rd);
		op(1'b0, 6'h1A, 1'b0, 1'b0, fpc_pkg::ST_OK, n_ok);
		op(1'b0, 6'h0A, 1'b0, 1'b0, fpc_pkg::ST_REFUSED, n_ref);
		op(1'b0, 6'h1B, 1'b0, 1'b0, fpc_pkg::ST_REFUSED, n);
		`CHK(n_ok - n_ref, P)
		`CHK(n > 0, 1'b1)
	endtask
	// Redirect with lock, then locked page refused for commit and erase
	task automatic t_lock();
		op(1'b0, 6'h25, 1'b1, 1'b1, fpc_pkg::ST_OK, n);
		`CHK(n, n_ok)
		op(1'b0, 6'h25, 1'b1, 1'b0, fpc_pkg::ST_REFUSED, n);
		`CHK(n, n_ref)
		op(1'b1, 6'h25, 1'b0, 1'b0, fpc_pkg::ST_REFUSED, n);
		op(1'b1, 6'h26, 1'b0, 1'b0, fpc_pkg::ST_OK, n);
	endtask
	// ECC hook, then write count above a lowered threshold
	task automatic t_codes();
		wb(1'b1, fpc_pkg::A_CTRL, 32'h00000001, rd);
		op(1'b0, 6'h1A, 1'b0, 1'b0, fpc_pkg::ST_ECC, n);
		wb(1'b1, fpc_pkg::A_CTRL, 32'h00000000, rd);
		wb(1'b1, fpc_pkg::A_THRESH, 32'h00000001, rd);
		op(1'b0, 6'h1A, 1'b0, 1'b0, fpc_pkg::ST_WEAR, n);
		wb(1'b1, fpc_pkg::A_THRESH, 32'h000003E8, rd);
	endtask
	// Interrupt masked, enabled, cleared; status not writable
	task automatic t_irq();
		wb(1'b1, fpc_pkg::A_IRQ_CLR, 32'h00000003, rd);
		wb(1'b1, fpc_pkg::A_IRQ_EN, 32'h00000000, rd);
		op(1'b0, 6'h0A, 1'b0, 1'b0, fpc_pkg::ST_REFUSED, n);
		wb(1'b0, fpc_pkg::A_IRQ_STAT, 32'h0, rd);
		`CHK(rd, 32'h00000003)
		`CHK(irq, 1'b0)
		wb(1'b1, fpc_pkg::A_IRQ_EN, 32'h00000002, rd);
		wb(1'b0, fpc_pkg::A_IRQ_EN, 32'h0, rd);
		`CHK(rd, 32'h00000002)
		repeat (3) @(negedge clk_i);
		`CHK(irq, 1'b1)
		wb(1'b1, fpc_pkg::A_IRQ_CLR, 32'h00000002, rd);
		wb(1'b1, fpc_pkg::A_IRQ_STAT, 32'h00000003, rd);
		repeat (3) @(negedge clk_i);
		`CHK(irq, 1'b0)
		wb(1'b0, fpc_pkg::A_IRQ_STAT, 32'h0, rd);
		`CHK(rd, 32'h00000001)
	endtask
	// Inputs at time zero, reset for 4 cycles, then scenarios
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_dw = 32'h0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_commit();
		t_lock();
		t_codes();
		t_irq();
		report_and_stop();
	end
endmodule
